/* scan_packet_engine.sv */
// scan packet engine: command bytes in, tck/tms/tdi out, tdo bytes back, axi4-lite status
`include "scan_defs.svh"
`default_nettype none
module scan_packet_engine (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // command byte stream
  input wire logic [7:0] cmd_data,
  input wire logic cmd_valid,
  output logic cmd_ready,
  // response byte stream
  output logic [7:0] rsp_data,
  output logic rsp_valid,
  input wire logic rsp_ready,
  // test port pins
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  // axi4-lite slave
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  // ****************
  // declarations
  // ****************
  scan_pkg::eng_state_t state, next_state;
  logic [2:0] div_cnt, next_div;
  logic [7:0] bits_left, next_left;
  logic [2:0] bit_idx, next_idx;
  logic [7:0] sreg, next_sreg;
  logic [7:0] hdr, next_hdr;
  logic pk, next_pk;
  logic [7:0] rbuf, next_rbuf;
  logic scan_done, next_done;
  logic rsv_seen, next_rsv;
  logic [7:0] drop_cnt, next_drop;
  logic [7:0] last_len, next_last_len;
  logic next_tck, next_tms, next_tdi, next_cmd_ready, next_rsp_valid;
  logic [7:0] next_rsp_data;
  logic tdo_meta, tdo_sync;
  logic take, data_mode;
  logic ctrl_en, next_ctrl_en;
  logic rsv_clr;
  logic aw_hold, next_aw_hold, w_hold, next_w_hold;
  logic [7:0] aw_addr, next_aw_addr;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  scan_decode_if dec_if ();

  scan_header_decode u_dec (
    .dec(dec_if)
  );

  assign take = cmd_valid && cmd_ready;
  assign data_mode = !hdr[`HDR_FIX_BIT] && !pk;
  assign dec_if.hdr_byte = (state == scan_pkg::st_idle) ? cmd_data : hdr;
  assign dec_if.len_byte = cmd_data;

  // ****************
  // tdo synchroniser
  // ****************
  always_ff @(posedge clk) begin
    if (rst) begin
      tdo_meta <= 1'b0;
      tdo_sync <= 1'b0;
    end else begin
      tdo_meta <= tdo;
      tdo_sync <= tdo_meta;
    end
  end

  // ****************
  // scan engine
  // ****************
  always_comb begin
    next_state = state;
    next_div = div_cnt;
    next_left = bits_left;
    next_idx = bit_idx;
    next_sreg = sreg;
    next_hdr = hdr;
    next_pk = pk;
    next_rbuf = rbuf;
    next_done = scan_done;
    next_drop = drop_cnt;
    next_last_len = last_len;
    next_tck = tck;
    next_tms = tms;
    next_tdi = tdi;
    next_rsp_valid = rsp_valid;
    next_rsp_data = rsp_data;
    // set wins over a software clear in the same cycle
    next_rsv = rsv_seen && !rsv_clr;
    case (state)
      scan_pkg::st_idle: begin
        if (take) begin
          if (dec_if.is_scan_hdr) begin
            next_hdr = cmd_data;
            next_rsv = next_rsv || dec_if.reserved_set;
            next_state = scan_pkg::st_len;
          end else begin
            // other packet types are not handled here: dropped and counted
            next_drop = drop_cnt + 8'h01;
          end
        end
      end
      scan_pkg::st_len: begin
        if (take) begin
          next_left = dec_if.scan_len;
          next_last_len = dec_if.scan_len;
          next_idx = 3'h0;
          next_div = 3'h0;
          next_pk = dec_if.packed_fmt;
          next_rbuf = 8'h00;
          next_sreg = {2'h0, dec_if.packed_tdi};
          if (dec_if.packed_fmt || dec_if.use_fixed_level_flag) begin
            next_state = scan_pkg::st_low;
          end else begin
            next_state = scan_pkg::st_data;
          end
        end
      end
      scan_pkg::st_data: begin
        if (take) begin
          next_sreg = cmd_data;
          next_div = 3'h0;
          next_state = scan_pkg::st_low;
        end
      end
      scan_pkg::st_low: begin
        next_tck = 1'b0;
        next_tms = (bits_left == 8'h01) ? hdr[`HDR_TMS_BIT] : 1'b0;
        next_tdi = hdr[`HDR_FIX_BIT] ? hdr[`HDR_LVL_BIT] : sreg[0];
        if (div_cnt == 3'(`TCK_HALF_CYCLES - 1)) begin
          next_div = 3'h0;
          next_tck = 1'b1;
          next_state = scan_pkg::st_high;
        end else begin
          next_div = div_cnt + 3'h1;
        end
      end
      scan_pkg::st_high: begin
        if (div_cnt == 3'(`TCK_HALF_CYCLES - 1)) begin
          // tdo sampled late in the high phase, well after the target changed it
          next_div = 3'h0;
          next_tck = 1'b0;
          next_sreg = sreg >> 1;
          next_idx = bit_idx + 3'h1;
          next_left = bits_left - 8'h01;
          next_done = (bits_left == 8'h01);
          if (hdr[`HDR_CAP_BIT]) begin
            next_rbuf[bit_idx] = tdo_sync;
          end
          if (hdr[`HDR_CAP_BIT] && (bit_idx == 3'h7 || bits_left == 8'h01)) begin
            next_rsp_data = next_rbuf;
            next_rsp_valid = 1'b1;
            next_rbuf = 8'h00;
            next_state = scan_pkg::st_push;
          end else if (bits_left == 8'h01) begin
            next_state = scan_pkg::st_idle;
          end else if (data_mode && bit_idx == 3'h7) begin
            next_state = scan_pkg::st_data;
          end else begin
            next_state = scan_pkg::st_low;
          end
        end else begin
          next_div = div_cnt + 3'h1;
        end
      end
      scan_pkg::st_push: begin
        if (rsp_ready) begin
          next_rsp_valid = 1'b0;
          if (scan_done) begin
            next_state = scan_pkg::st_idle;
          end else if (data_mode && bit_idx == 3'h0) begin
            next_state = scan_pkg::st_data;
          end else begin
            next_state = scan_pkg::st_low;
          end
        end
      end
      default: begin
        next_state = scan_pkg::st_idle;
      end
    endcase
    next_cmd_ready = ctrl_en && (next_state == scan_pkg::st_idle || next_state == scan_pkg::st_len
      || next_state == scan_pkg::st_data);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= scan_pkg::st_idle;
      div_cnt <= 3'h0;
      bits_left <= 8'h00;
      bit_idx <= 3'h0;
      sreg <= 8'h00;
      hdr <= 8'h00;
      pk <= 1'b0;
      rbuf <= 8'h00;
      scan_done <= 1'b0;
      rsv_seen <= 1'b0;
      drop_cnt <= 8'h00;
      last_len <= 8'h00;
      tck <= 1'b0;
      tms <= 1'b0;
      tdi <= 1'b0;
      cmd_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data <= 8'h00;
    end else begin
      state <= next_state;
      div_cnt <= next_div;
      bits_left <= next_left;
      bit_idx <= next_idx;
      sreg <= next_sreg;
      hdr <= next_hdr;
      pk <= next_pk;
      rbuf <= next_rbuf;
      scan_done <= next_done;
      rsv_seen <= next_rsv;
      drop_cnt <= next_drop;
      last_len <= next_last_len;
      tck <= next_tck;
      tms <= next_tms;
      tdi <= next_tdi;
      cmd_ready <= next_cmd_ready;
      rsp_valid <= next_rsp_valid;
      rsp_data <= next_rsp_data;
    end
  end

  // ****************
  // axi4-lite registers
  // ****************
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_addr = aw_addr;
    next_w_hold = w_hold;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_arready = arready;
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    next_ctrl_en = ctrl_en;
    rsv_clr = 1'b0;
    if (awvalid && awready) begin
      next_aw_hold = 1'b1;
      next_aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      next_w_hold = 1'b1;
      next_w_data = wdata;
      next_w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_hold && w_hold && !bvalid) begin
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `RESP_OKAY;
      case (aw_addr)
        `REG_CTRL: begin
          if (w_strb[0]) begin
            next_ctrl_en = w_data[0];
          end
        end
        `REG_STATUS: begin
          rsv_clr = w_strb[0] && w_data[1];
        end
        `REG_DROP: begin
          next_bresp = `RESP_OKAY;
        end
        default: begin
          next_bresp = `RESP_SLVERR;
        end
      endcase
    end
    next_awready = !next_aw_hold;
    next_wready = !next_w_hold;
    if (rvalid && rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    if (arvalid && arready) begin
      next_rvalid = 1'b1;
      next_arready = 1'b0;
      next_rresp = `RESP_OKAY;
      case (araddr)
        `REG_CTRL: next_rdata = {31'h0, ctrl_en};
        `REG_STATUS: next_rdata = {16'h0, last_len, 6'h0, rsv_seen, state != scan_pkg::st_idle};
        `REG_DROP: next_rdata = {24'h0, drop_cnt};
        default: begin
          next_rdata = 32'h0;
          next_rresp = `RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      aw_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_hold <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0;
      rresp <= `RESP_OKAY;
      ctrl_en <= `CTRL_RESET;
    end else begin
      aw_hold <= next_aw_hold;
      aw_addr <= next_aw_addr;
      w_hold <= next_w_hold;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      awready <= next_awready;
      wready <= next_wready;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      arready <= (next_arready || !arready && !rvalid && !next_rvalid);
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
      ctrl_en <= next_ctrl_en;
    end
  end

  // ****************
  // assertions
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hdr_detect;
    (state == scan_pkg::st_idle && take && cmd_data[7:5] == 3'h4) |=> state == scan_pkg::st_len;
  endproperty
  a_hdr_detect: assert property (p_hdr_detect) else $error("header not recognised");
  property p_tms_last;
    ($rose(tck) && bits_left == 8'h01) |-> tms == hdr[`HDR_TMS_BIT];
  endproperty
  a_tms_last: assert property (p_tms_last) else $error("wrong tms on final cycle");
  property p_tms_low;
    ($rose(tck) && bits_left != 8'h01) |-> !tms;
  endproperty
  a_tms_low: assert property (p_tms_low) else $error("tms high before final cycle");
  property p_capture;
    $rose(rsp_valid) |-> hdr[`HDR_CAP_BIT];
  endproperty
  a_capture: assert property (p_capture) else $error("response without capture enabled");
  property p_fixed_tdi;
    ($rose(tck) && hdr[`HDR_FIX_BIT]) |-> tdi == hdr[`HDR_LVL_BIT];
  endproperty
  a_fixed_tdi: assert property (p_fixed_tdi) else $error("tdi not at fixed level");
  property p_data_tdi;
    ($rose(tck) && !hdr[`HDR_FIX_BIT]) |-> tdi == sreg[0];
  endproperty
  a_data_tdi: assert property (p_data_tdi) else $error("tdi not from data bits");
  property p_len;
    (state == scan_pkg::st_len && take && !cmd_data[7]) |=> bits_left == {1'b0, $past(cmd_data[6:0])} + 8'h01;
  endproperty
  a_len: assert property (p_len) else $error("scan length wrong");
  property p_short_end;
    (state == scan_pkg::st_len && take && (cmd_data[7] || hdr[`HDR_FIX_BIT])) |=> state == scan_pkg::st_low;
  endproperty
  a_short_end: assert property (p_short_end) else $error("two byte packet fetched more");
  property p_stall;
    (rsp_valid && !rsp_ready) |=> rsp_valid && $stable(rsp_data) && $stable(tck) && state == scan_pkg::st_push;
  endproperty
  a_stall: assert property (p_stall) else $error("scan moved while response waits");
  property p_first_bit;
    (state == scan_pkg::st_data && take) |=> sreg == $past(cmd_data) ##[1:8] tdi == sreg[0];
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("data byte bit 0 not used first");
  c_packed: cover property (state == scan_pkg::st_len && take && cmd_data[7]);
  c_push: cover property (rsp_valid && rsp_ready);
  c_stall: cover property (rsp_valid && !rsp_ready ##1 rsp_valid && rsp_ready);
  c_data: cover property (state == scan_pkg::st_high ##1 state == scan_pkg::st_data);
endmodule
`default_nettype wire

/* scan_defs.svh */
// constants for the scan packet engine: header fields, register map, timing
`ifndef SCAN_DEFS_SVH
`define SCAN_DEFS_SVH

// ****************
// packet fields
// ****************
`define HDR_OPCODE 3'h4
`define HDR_RSV_BIT 4
`define HDR_TMS_BIT 3
`define HDR_CAP_BIT 2
`define HDR_LVL_BIT 1
`define HDR_FIX_BIT 0
`define LEN_PACKED_BIT 7
`define PACKED_MAX_BITS 6

// ****************
// register map
// ****************
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DROP 8'h08
`define CTRL_RESET 1'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// ****************
// timing
// ****************
`define CLK_PERIOD_NS 20
`define TCK_PERIOD_NS 160
`define TCK_HALF_CYCLES ((`TCK_PERIOD_NS / `CLK_PERIOD_NS) / 2)

`endif

/* scan_pkg.sv */
// types shared by the scan packet engine
`default_nettype none
package scan_pkg;
  typedef enum logic [5:0] {
    st_idle = 6'h01,
    st_len = 6'h02,
    st_data = 6'h04,
    st_low = 6'h08,
    st_high = 6'h10,
    st_push = 6'h20
  } eng_state_t;
endpackage
`default_nettype wire

/* scan_decode_if.sv */
// carrier between the engine and its header and length byte decoder
`default_nettype none
interface scan_decode_if;
  logic [7:0] hdr_byte;
  logic [7:0] len_byte;
  logic is_scan_hdr;
  logic reserved_set;
  logic tms_last;
  logic capture;
  logic fixed_level;
  logic use_fixed_level_flag;
  logic packed_fmt;
  logic [5:0] packed_tdi;
  logic [7:0] scan_len;
  modport decoder (
    input hdr_byte, len_byte,
    output is_scan_hdr, reserved_set, tms_last, capture, fixed_level, use_fixed_level_flag,
    output packed_fmt, packed_tdi, scan_len
  );
  modport engine (
    output hdr_byte, len_byte,
    input is_scan_hdr, reserved_set, tms_last, capture, fixed_level, use_fixed_level_flag,
    input packed_fmt, packed_tdi, scan_len
  );
endinterface
`default_nettype wire

/* scan_header_decode.sv */
// decode of the scan header byte and the length byte
`include "scan_defs.svh"
`default_nettype none
module scan_header_decode (
  // decoded fields
  scan_decode_if.decoder dec
);
  logic [7:0] packed_len;

  always_comb begin
    dec.is_scan_hdr = (dec.hdr_byte[7:5] == `HDR_OPCODE);
    dec.reserved_set = dec.hdr_byte[`HDR_RSV_BIT];
    dec.tms_last = dec.hdr_byte[`HDR_TMS_BIT];
    dec.capture = dec.hdr_byte[`HDR_CAP_BIT];
    dec.fixed_level = dec.hdr_byte[`HDR_LVL_BIT];
    dec.use_fixed_level_flag = dec.hdr_byte[`HDR_FIX_BIT];
    dec.packed_fmt = dec.len_byte[`LEN_PACKED_BIT];
    dec.packed_tdi = dec.len_byte[5:0];
    // highest start flag gives the length; no flag at all falls back to one cycle
    packed_len = 8'h01;
    for (int i = 1; i <= `PACKED_MAX_BITS; i++) begin
      if (dec.len_byte[i]) begin
        packed_len = 8'(i);
      end
    end
    if (dec.packed_fmt) begin
      dec.scan_len = packed_len;
    end else begin
      dec.scan_len = {1'b0, dec.len_byte[6:0]} + 8'h01;
    end
  end
endmodule
`default_nettype wire

/* tap_target_model.sv */
// behavioural target test port: logs tms and tdi per cycle, returns a tdo pattern
`default_nettype none
module tap_target_model #(
  parameter logic [127:0] PAT = 128'h1234_5678_9ABC_DEF0_0FED_CBA9_8765_4321
) (
  // clock and log clear
  input wire logic clk,
  input wire logic clr,
  // test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  logic tck_q = 1'b0;
  int cnt = 0;
  logic tdi_log [256];
  logic tms_log [256];
  initial tdo = PAT[0];
  // ****************
  // edge detection
  // ****************
  // tdo moves only after a falling tck, as a real target would
  always @(posedge clk) begin
    tck_q <= tck;
    if (clr) begin
      cnt <= 0;
      tdo <= PAT[0];
    end else if (tck && !tck_q) begin
      tdi_log[cnt[7:0]] <= tdi;
      tms_log[cnt[7:0]] <= tms;
    end else if (!tck && tck_q) begin
      cnt <= cnt + 1;
      tdo <= PAT[(cnt + 1) % 128];
    end
  end
endmodule
`default_nettype wire

/* testbench.sv */
// self-checking bench for the scan packet engine
`include "scan_defs.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [127:0] PAT = 128'h5A3C_96E1_0FF0_C3A5_7E81_2D4B_B4D2_18E7;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic clr = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic cmd_valid = 1'b0;
  logic rsp_ready = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] rsp_data;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic cmd_ready, rsp_valid, tck, tms, tdi, tdo;
  logic awready, wready, bvalid, arready, rvalid;
  int err_total = 0;
  int num_checks = 0;
  always #10 clk = ~clk;
  scan_packet_engine dut (.clk(clk), .rst(rst), .cmd_data(cmd_data), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp_data(rsp_data), .rsp_valid(rsp_valid), .rsp_ready(rsp_ready),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  tap_target_model #(.PAT(PAT)) tap (.clk(clk), .clr(clr), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  // ****************
  // shared tasks
  // ****************
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    logic ta, tw, ok;
    logic [1:0] r;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!ok && n < 100) begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      ok = bvalid === 1'b1;
      r = bresp;
      @(posedge clk);
      n++;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!ok) begin
      err_total++;
      end_of_test();
    end
    chk(32'(r), 32'(er));
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    logic ta, ok;
    logic [31:0] d;
    logic [1:0] r;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!ok && n < 100) begin
      @(negedge clk);
      ta = arvalid && arready;
      ok = rvalid === 1'b1;
      d = rdata;
      r = rresp;
      @(posedge clk);
      n++;
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!ok) begin
      err_total++;
      end_of_test();
    end
    chk(d, ed);
    chk(32'(r), 32'(er));
  endtask
  // sends a byte list, drains responses (stalled for hold cycles), then judges the wire log
  task automatic run_scan(input logic [7:0] pkt[$], input int nb, input logic [127:0] etdi,
    input logic etms, input logic cap, input int hold);
    int i, j, k, n, nr;
    logic ct, rt, st, tq;
    logic [7:0] e;
    i = 0;
    k = 0;
    n = 0;
    st = 1'b0;
    tq = 1'b0;
    nr = cap ? (nb + 7) / 8 : 0;
    @(posedge clk);
    clr <= 1'b1;
    cmd_valid <= 1'b1;
    cmd_data <= pkt[0];
    while (n < 20000 && !(i == pkt.size() && tap.cnt == nb && k == nr)) begin
      @(negedge clk);
      ct = cmd_valid && cmd_ready;
      rt = rsp_valid && rsp_ready;
      if (st) chk(32'(tck), 32'(tq));
      st = rsp_valid && !rsp_ready;
      tq = tck;
      if (rt) begin
        for (j = 0; j < 8; j++) e[j] = (k * 8 + j < nb) ? PAT[k * 8 + j] : 1'b0;
        chk(32'(rsp_data), 32'(e));
        k++;
      end
      @(posedge clk);
      n++;
      clr <= 1'b0;
      if (ct) i++;
      cmd_valid <= i < pkt.size();
      cmd_data <= (i < pkt.size()) ? pkt[i] : 8'h00;
      rsp_ready <= n >= hold;
    end
    if (n >= 20000) begin
      err_total++;
      end_of_test();
    end
    rsp_ready <= 1'b0;
    repeat (20) @(posedge clk);
    @(negedge clk);
    chk(32'(tap.cnt), 32'(nb));
    chk(32'(rsp_valid), 32'h0);
    for (i = 0; i < nb; i++) begin
      chk(32'(tap.tdi_log[i]), 32'(etdi[i]));
      chk(32'(tap.tms_log[i]), (i == nb - 1) ? 32'(etms) : 32'h0);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_regs();
    axi_rd(`REG_CTRL, 32'h1, `RESP_OKAY);
    axi_rd(8'h0C, 32'h0, `RESP_SLVERR);
    axi_wr(8'h0C, 32'h1, `RESP_SLVERR);
    axi_wr(`REG_DROP, 32'hFF, `RESP_OKAY);
    axi_rd(`REG_DROP, 32'h0, `RESP_OKAY);
    axi_wr(`REG_CTRL, 32'h0, `RESP_OKAY);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(cmd_ready), 32'h0);
    axi_wr(`REG_CTRL, 32'h1, `RESP_OKAY);
  endtask
  // two fixed-level packets back to back: the second header must not be eaten as data
  task automatic s_fixed_pair();
    run_scan({8'h83, 8'h00, 8'h89, 8'h00}, 2, 128'h1, 1'b1, 1'b0, 0);
  endtask
  // level bit set but ignored; 21 cycles from three data bytes
  // then 10 cycles without capture: the second data byte is fetched straight after bit 8
  task automatic s_data_21();
    run_scan({8'h86, 8'h14, 8'hA5, 8'h3C, 8'h15}, 21, 128'h153CA5, 1'b0, 1'b1, 0);
    run_scan({8'h88, 8'h09, 8'h5A, 8'h03}, 10, 128'h35A, 1'b1, 1'b0, 0);
  endtask
  // longest scan with the response sink stalled
  task automatic s_max_stall();
    run_scan({8'h8D, 8'h7F}, 128, 128'h0, 1'b1, 1'b1, 300);
    axi_rd(`REG_STATUS, 32'h00008000, `RESP_OKAY);
  endtask
  task automatic s_packed();
    run_scan({8'h84, 8'hE5}, 6, 128'h25, 1'b0, 1'b1, 0);
    run_scan({8'h8B, 8'h8A}, 3, 128'h7, 1'b1, 1'b0, 0);
  endtask
  // stray bytes are dropped; reserved header bit only flags status
  task automatic s_drop_reserved();
    run_scan({8'h20, 8'hA0, 8'h99, 8'h00}, 1, 128'h0, 1'b1, 1'b0, 0);
    axi_rd(`REG_DROP, 32'h2, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h00000102, `RESP_OKAY);
    axi_wr(`REG_STATUS, 32'h2, `RESP_OKAY);
    axi_rd(`REG_STATUS, 32'h00000100, `RESP_OKAY);
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    s_regs();
    s_fixed_pair();
    s_data_21();
    s_max_stall();
    s_packed();
    s_drop_reserved();
    end_of_test();
  end
endmodule
`default_nettype wire
